// File: dual_output_calibration_regs.svh
// register numbers, command codes and factory values of the calibration register bank
`ifndef DUAL_OUTPUT_CALIBRATION_REGS_SVH
`define DUAL_OUTPUT_CALIBRATION_REGS_SVH

// ==========================================================
// register numbers as seen on the field-bus
`define DOCR_REG_CH1_OUT      16'h9c71
`define DOCR_REG_CH2_OUT      16'h9c72
`define DOCR_REG_CH1_RANGE    16'h9cd1
`define DOCR_REG_CH2_RANGE    16'h9cd2
`define DOCR_REG_NEG_UP       16'h9cf1
`define DOCR_REG_NEG_DN       16'h9cf2
`define DOCR_REG_POS_UP       16'h9cf3
`define DOCR_REG_POS_DN       16'h9cf4
`define DOCR_REG_CMD          16'h9d31

// ==========================================================
// command codes and channel select values
`define DOCR_CMD_NOP          16'h0000
`define DOCR_CMD_RESET        16'h0001
`define DOCR_CMD_WREN         16'h0002
`define DOCR_CMD_HOSTINIT     16'h0005
`define DOCR_SEL_CH1          16'h0000
`define DOCR_SEL_CH2          16'h0001

// ==========================================================
// field positions of the range register
`define DOCR_RANGE_LSB        0
`define DOCR_RANGE_MSB        1
`define DOCR_SLOPE_LSB        3
`define DOCR_SLOPE_MSB        7

// ==========================================================
// factory values
`define DOCR_DEF_SLAVE_ADDR   8'h01
`define DOCR_DEF_BAUD         16'h2580
`define DOCR_DEF_PARITY       2'h0
`define DOCR_DEF_RESP_MS      8'h03
`define DOCR_DEF_QUERY_MS     8'h00
`define DOCR_DEF_CONV_HZ      8'h3c
`define DOCR_DEF_WDOG         16'hffff
`define DOCR_DEF_SLOPE        5'h00
`define DOCR_DEF_INIT_VALUE   16'h0000
`define DOCR_FS_NEG           16'h0000
`define DOCR_FS_POS           16'hffff

`endif

// File: docr_pkg.sv
// types shared by the calibration register bank
package docr_pkg;

    // ==========================================================
    // output range codes, in register order
    typedef enum logic [1:0] {
        DOCR_RANGE_0_10V,
        DOCR_RANGE_PM10V,
        DOCR_RANGE_4_20MA,
        DOCR_RANGE_0_20MA
    } docr_range_t;

    // register access from the field-bus framer
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] data;
    } docr_req_t;

    // link defaults handed to the serial side
    typedef struct packed {
        logic [7:0]  slave_addr;
        logic [15:0] baud;
        logic [1:0]  parity;
        logic [7:0]  resp_ms;
        logic [7:0]  query_ms;
        logic [7:0]  conv_hz;
        logic [15:0] wdog;
    } docr_link_cfg_t;

    // per channel setup and setpoint
    typedef struct packed {
        logic [15:0] value;
        docr_range_t rng;
        logic [4:0]  slope;
        logic [15:0] init;
    } docr_chan_t;

endpackage : docr_pkg

// File: docr_top.sv
// two-channel output calibration and default configuration register bank
`timescale 1ns/100ps
`include "dual_output_calibration_regs.svh"

// Behaviour
// [R1] link defaults: address 1, 9600 baud, no parity, 3 ms / 0 ms delays, 60 Hz
// [R2] each channel resets to 0-10 V range, immediate slope, initial output 0 V
// [R3] watchdog word resets to all ones, meaning watchdog disabled
// [R4] range register codes: 0 0-10 V, 1 +/-10 V, 2 4-20 mA, 3 0-20 mA
// [R5] output register 0000 forces negative full scale, FFFF positive full scale
// [R6] trim writes only take effect after command 0x0002 write-enables the module
// [R7] two registers raise and lower negative full scale trim of channel selected by data
// [R8] two registers raise and lower positive full scale trim of channel selected by data
// [R9] host selects range, forces full scale, enables, then trims; negative point first
// [R10] host may repeat trim writes until the measured output matches
// [R11] host repeats trimming for each range in the documented order
// [R12] each accepted trim write moves output by one LSB immediately
// [R13] host must not write-protect just before writing an output register
// [R14] separate negative and positive trims kept per channel and range
module docr_top #(
    parameter int TW = 8,
    parameter int DW = 18
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // register access
    input  wire docr_pkg::docr_req_t      req_i,
    output logic                          ack_o,
    output logic [15:0]                   rdata_o,
    // configuration and converter codes
    output docr_pkg::docr_link_cfg_t      link_cfg_o,
    output docr_pkg::docr_chan_t [1:0]    chan_o,
    output logic                          wr_en_o,
    output logic [1:0][DW-1:0]            dac_o
);
    import docr_pkg::*;

    localparam docr_link_cfg_t LINK_DEF = '{
        slave_addr: `DOCR_DEF_SLAVE_ADDR, baud: `DOCR_DEF_BAUD,
        parity: `DOCR_DEF_PARITY, resp_ms: `DOCR_DEF_RESP_MS,
        query_ms: `DOCR_DEF_QUERY_MS, conv_hz: `DOCR_DEF_CONV_HZ,
        wdog: `DOCR_DEF_WDOG};
    localparam docr_chan_t CHAN_DEF = '{
        value: `DOCR_DEF_INIT_VALUE, rng: DOCR_RANGE_0_10V,
        slope: `DOCR_DEF_SLOPE, init: `DOCR_DEF_INIT_VALUE};
    localparam logic signed [TW-1:0] TRIM_MAX = {1'b0, {(TW-1){1'b1}}};
    localparam logic signed [TW-1:0] TRIM_MIN = {1'b1, {(TW-1){1'b0}}};

    // ==========================================================
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    // two stages so release never lands near an edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // register state
    docr_link_cfg_t               link_cfg, next_link_cfg;
    docr_chan_t [1:0]             chan, next_chan;
    logic signed [1:0][3:0][TW-1:0] trim_neg, next_trim_neg;
    logic signed [1:0][3:0][TW-1:0] trim_pos, next_trim_pos;
    logic                         wr_en, next_wr_en;
    logic                         ack, next_ack;
    logic [15:0]                  rdata, next_rdata;
    logic [1:0][DW-1:0]           dac, next_dac;
    logic                         sel;
    logic                         trim_ok;
    docr_range_t                  sel_rng;

    // decode of reads and writes; trims need the enable and a 0/1 select
    always_comb begin
        next_link_cfg = link_cfg;
        next_chan     = chan;
        next_trim_neg = trim_neg;
        next_trim_pos = trim_pos;
        next_wr_en    = wr_en;
        next_ack      = req_i.wr | req_i.rd;
        next_rdata    = rdata;
        sel           = req_i.data[0];
        sel_rng       = chan[sel].rng;
        trim_ok       = wr_en && (req_i.data[15:1] == 15'h0000); // see [R6]
        if (req_i.wr) begin
            unique case (req_i.addr)
                `DOCR_REG_CH1_OUT: next_chan[0].value = req_i.data; // see [R5]
                `DOCR_REG_CH2_OUT: next_chan[1].value = req_i.data; // see [R5]
                `DOCR_REG_CH1_RANGE, `DOCR_REG_CH2_RANGE: begin
                    // see [R4]
                    next_chan[req_i.addr[1]].rng =
                        docr_range_t'(req_i.data[`DOCR_RANGE_MSB:`DOCR_RANGE_LSB]);
                    next_chan[req_i.addr[1]].slope =
                        req_i.data[`DOCR_SLOPE_MSB:`DOCR_SLOPE_LSB];
                end
                `DOCR_REG_NEG_UP: begin
                    if (trim_ok && trim_neg[sel][sel_rng] != TRIM_MAX) begin
                        next_trim_neg[sel][sel_rng] = trim_neg[sel][sel_rng] + 1'b1; // see [R7] [R12] [R14]
                    end
                end
                `DOCR_REG_NEG_DN: begin
                    if (trim_ok && trim_neg[sel][sel_rng] != TRIM_MIN) begin
                        next_trim_neg[sel][sel_rng] = trim_neg[sel][sel_rng] - 1'b1; // see [R7] [R12]
                    end
                end
                `DOCR_REG_POS_UP: begin
                    if (trim_ok && trim_pos[sel][sel_rng] != TRIM_MAX) begin
                        next_trim_pos[sel][sel_rng] = trim_pos[sel][sel_rng] + 1'b1; // see [R8] [R12] [R14]
                    end
                end
                `DOCR_REG_POS_DN: begin
                    if (trim_ok && trim_pos[sel][sel_rng] != TRIM_MIN) begin
                        next_trim_pos[sel][sel_rng] = trim_pos[sel][sel_rng] - 1'b1; // see [R8] [R12]
                    end
                end
                `DOCR_REG_CMD: begin
                    // any command but enable or no-op closes the trim window again
                    unique case (req_i.data)
                        `DOCR_CMD_WREN: next_wr_en = 1'b1; // see [R6]
                        `DOCR_CMD_NOP: next_wr_en = wr_en;
                        `DOCR_CMD_RESET: begin
                            next_wr_en = 1'b0;
                            if (wr_en) begin
                                next_chan[0].value = chan[0].init;
                                next_chan[1].value = chan[1].init;
                            end
                        end
                        `DOCR_CMD_HOSTINIT: begin
                            next_wr_en    = 1'b0;
                            next_link_cfg = LINK_DEF; // see [R1] [R3]
                        end
                        default: next_wr_en = 1'b0;
                    endcase
                end
                default: next_ack = 1'b1;
            endcase
        end
        if (req_i.rd) begin
            // write-only and unmapped numbers read as zero
            unique case (req_i.addr)
                `DOCR_REG_CH1_OUT: next_rdata = chan[0].value;
                `DOCR_REG_CH2_OUT: next_rdata = chan[1].value;
                `DOCR_REG_CH1_RANGE, `DOCR_REG_CH2_RANGE: begin
                    next_rdata = {8'h00, chan[req_i.addr[1]].slope, 1'b0,
                                  chan[req_i.addr[1]].rng};
                end
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // calibrated converter code per channel
    // the trims blend linearly between the two end points, so each trim step
    // shows as one code at its own end point and leaves the other untouched
    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic signed [TW-1:0]  neg_t;
        logic signed [TW-1:0]  pos_t;
        logic signed [TW:0]    span;
        logic signed [TW+17:0] prod;
        assign neg_t = trim_neg[g][chan[g].rng]; // see [R14]
        assign pos_t = trim_pos[g][chan[g].rng];
        assign span  = (TW+1)'(pos_t) - (TW+1)'(neg_t);
        // half a code of rounding: without it the first upward step of the
        // positive trim vanishes at full scale, since the scale is 65535/65536
        assign prod  = (TW+18)'(span) * (TW+18)'(signed'({2'b00, chan[g].value}))
                     + (TW+18)'(32'sh0000_8000);
        assign next_dac[g] = DW'(signed'({2'b00, chan[g].value})) + DW'(neg_t)
                           + DW'(prod >>> 16); // see [R5] [R12]
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            link_cfg <= LINK_DEF; // see [R1] [R3]
            chan     <= {CHAN_DEF, CHAN_DEF}; // see [R2]
            trim_neg <= '0;
            trim_pos <= '0;
            wr_en    <= 1'b0;
            ack      <= 1'b0;
            rdata    <= 16'h0000;
            dac      <= '0;
        end else begin
            link_cfg <= next_link_cfg;
            chan     <= next_chan;
            trim_neg <= next_trim_neg;
            trim_pos <= next_trim_pos;
            wr_en    <= next_wr_en;
            ack      <= next_ack;
            rdata    <= next_rdata;
            dac      <= next_dac;
        end
    end

    assign ack_o      = ack;
    assign rdata_o    = rdata;
    assign link_cfg_o = link_cfg;
    assign chan_o     = chan;
    assign wr_en_o    = wr_en;
    assign dac_o      = dac;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    logic wr_trim;
    assign wr_trim = req_i.wr && (req_i.addr >= `DOCR_REG_NEG_UP)
                   && (req_i.addr <= `DOCR_REG_POS_DN);

    chk_link_defaults: assert property (link_cfg_o == LINK_DEF) // see [R1]
        else $error("link defaults lost");
    chk_wdog_off: assert property (link_cfg_o.wdog == 16'hffff) // see [R3]
        else $error("watchdog word not all ones");
    chk_trim_gate: assert property (wr_trim && !wr_en |=> $stable(trim_neg) && $stable(trim_pos)) // see [R6]
        else $error("trim taken without write enable");
    chk_wren_set: assert property (req_i.wr && req_i.addr == `DOCR_REG_CMD
                                   && req_i.data == `DOCR_CMD_WREN |=> wr_en_o) // see [R6]
        else $error("write enable not set");
    chk_neg_up_ch1: assert property (req_i.wr && req_i.addr == `DOCR_REG_NEG_UP && wr_en
        && req_i.data == `DOCR_SEL_CH1 && trim_neg[0][chan[0].rng] != TRIM_MAX
        |=> trim_neg[0][chan[0].rng] == $past(trim_neg[0][chan[0].rng]) + 1'b1) // see [R7]
        else $error("negative trim raise missed");
    chk_pos_dn_ch2: assert property (req_i.wr && req_i.addr == `DOCR_REG_POS_DN && wr_en
        && req_i.data == `DOCR_SEL_CH2 && trim_pos[1][chan[1].rng] != TRIM_MIN
        |=> trim_pos[1][chan[1].rng] == $past(trim_pos[1][chan[1].rng]) - 1'b1) // see [R8]
        else $error("positive trim lower missed");
    chk_force_neg: assert property (req_i.wr && req_i.addr == `DOCR_REG_CH1_OUT
        && req_i.data == `DOCR_FS_NEG && !wr_trim ##1 !req_i.wr
        |=> dac_o[0] == DW'(signed'(trim_neg[0][chan[0].rng]))) // see [R5] [R12]
        else $error("negative full scale code wrong");
    chk_range_code: assert property (req_i.wr && req_i.addr == `DOCR_REG_CH2_RANGE
        |=> chan_o[1].rng == $past(req_i.data[1:0])) // see [R4]
        else $error("range code not stored");
    chk_ack_once: assert property ((req_i.wr || req_i.rd) |=> ack_o)
        else $error("access not acknowledged");

    cov_trim_taken: cover property (wr_trim && wr_en);
    cov_enable_then_trim: cover property (wr_en_o ##[1:20] wr_trim);
    cov_force_pos: cover property (req_i.wr && req_i.addr == `DOCR_REG_CH2_OUT
                                   && req_i.data == `DOCR_FS_POS);

endmodule : docr_top

// File: docr_host_model.sv
// host field-bus master model that drives the calibration register bank
`timescale 1ns/100ps
`include "dual_output_calibration_regs.svh"
module docr_host_model
    import docr_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // register access
    output docr_pkg::docr_req_t req_o,
    input  wire logic        ack_i,
    input  wire logic [15:0] rdata_i
);
    int lost = 0;
    // idle with no request until the bench starts an access
    initial req_o = '0;
    // one-cycle request pulse, then wait for ack under a bound
    task automatic access(input logic w, input logic [15:0] a, d, output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req_o <= '{wr: w, rd: ~w, addr: a, data: d};
        @(posedge clk_i);
        // released bus shows inverted values, so stale data never looks valid
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 8);
        if (n >= 8) lost++;
        q = rdata_i;
    endtask : access
    // both outputs forced, never after a protect command
    task automatic force_out(input logic [15:0] v);
        logic [15:0] q;
        access(1'b1, `DOCR_REG_CH1_OUT, v, q);
        access(1'b1, `DOCR_REG_CH2_OUT, v, q);
    endtask : force_out
    // write-enable first, then repeat the trim step n times
    task automatic trim(input logic [15:0] a, ch, input int n);
        logic [15:0] q;
        access(1'b1, `DOCR_REG_CMD, `DOCR_CMD_WREN, q);
        repeat (n) access(1'b1, a, ch, q);
    endtask : trim
endmodule : docr_host_model

// File: dual_output_calibration_regs_test.sv
// self-checking bench for the calibration register bank
`timescale 1ns/100ps
`include "dual_output_calibration_regs.svh"
module dual_output_calibration_regs_test;
    import docr_pkg::*;
    // ==========================================================
    // clock, reset and wiring
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    docr_req_t        req;
    logic             ack;
    logic [15:0]      rdata;
    docr_link_cfg_t   link_cfg;
    docr_chan_t [1:0] chan;
    logic             wr_en;
    logic [1:0][17:0] dac;
    logic [15:0]      q;
    int               fails = 0;
    int               comparisons = 0;
    int               val [2];
    int               rng [2];
    int               tn [2][4];
    int               tp [2][4];
    int               order [4] = '{1, 0, 3, 2};
    always #4 clk_i = ~clk_i;
    docr_top docr_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .ack_o(ack),
        .rdata_o(rdata), .link_cfg_o(link_cfg), .chan_o(chan), .wr_en_o(wr_en), .dac_o(dac));
    docr_host_model docr_host_model_i (.clk_i(clk_i), .req_o(req), .ack_i(ack),
        .rdata_i(rdata));
    // ==========================================================
    // compare and access tasks
    task automatic chk(input logic [79:0] got, exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // expected code at the two forced end points only: the bottom shows the
    // negative trim alone, the top shows all ones plus the positive trim
    task automatic chk_dac(input int ch);
        int          want;
        logic [17:0] code;
        want = (val[ch] == 0) ? tn[ch][rng[ch]] : 65535 + tp[ch][rng[ch]];
        code = 18'(want);
        chk(80'(dac[ch]), 80'(code), "dac code");
    endtask : chk_dac
    task automatic wr(input logic [15:0] a, d);
        docr_host_model_i.access(1'b1, a, d, q);
    endtask : wr
    // trimmed converter codes land one cycle after the ack
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic set_range(input int r);
        wr(`DOCR_REG_CH1_RANGE, 16'(r));
        wr(`DOCR_REG_CH2_RANGE, 16'(r));
        rng = '{r, r};
    endtask : set_range
    task automatic force_out(input int v);
        docr_host_model_i.force_out(16'(v));
        val = '{v, v};
        settle();
    endtask : force_out
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
    // ==========================================================
    // tests
    initial begin
        tn = '{default: 0};
        tp = '{default: 0};
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        // link defaults: 9600 is 16'h2580, 60 Hz is 8'h3c
        chk(link_cfg, {8'h01, 16'h2580, 2'h0, 8'h03, 8'h00, 8'h3c, 16'hffff},
            "link");
        chk(chan, {2{16'h0000, 2'h0, 5'h00, 16'h0000}}, "chan defaults");
        chk({wr_en, dac}, 37'h0_0000_0000, "enable and codes");
        $display("test defaults done");
        // every range code on both channels, read back too
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 4; c++) begin
                wr(ch ? `DOCR_REG_CH2_RANGE : `DOCR_REG_CH1_RANGE, 16'(c));
                chk(chan[ch].rng, c, "range field");
                docr_host_model_i.access(1'b0, ch ? `DOCR_REG_CH2_RANGE : `DOCR_REG_CH1_RANGE,
                    16'h0000, q);
                chk(q, c, "range readback");
            end
        end
        docr_host_model_i.access(1'b0, `DOCR_REG_CMD, 16'h0000, q);
        chk(q, 16'h0000, "write-only read");
        $display("test ranges done");
        // full-scale forcing, then a trim refused without write-enable
        set_range(1);
        force_out(16'hffff);
        chk({chan[1].value, chan[0].value}, 32'hffff_ffff, "force positive");
        chk_dac(0);
        force_out(0);
        chk_dac(1);
        wr(`DOCR_REG_NEG_UP, `DOCR_SEL_CH1);
        settle();
        chk_dac(0);
        // enabled now, but a select other than 0 or 1 is still ignored
        docr_host_model_i.trim(`DOCR_REG_NEG_UP, 16'h0002, 1);
        settle();
        chk(wr_en, 1'b1, "enabled");
        chk_dac(0);
        chk_dac(1);
        $display("test forcing and protection done");
        // calibration per range in host order, negative point first
        for (int k = 0; k < 4; k++) begin
            set_range(order[k]);
            force_out(0);
            docr_host_model_i.trim(`DOCR_REG_NEG_UP, `DOCR_SEL_CH1, k + 1);
            docr_host_model_i.trim(`DOCR_REG_NEG_DN, `DOCR_SEL_CH2, 1);
            tn[0][order[k]] += k + 1;
            tn[1][order[k]] -= 1;
            settle();
            chk_dac(0);
            chk_dac(1);
            force_out(16'hffff);
            docr_host_model_i.trim(`DOCR_REG_POS_DN, `DOCR_SEL_CH1, k + 1);
            docr_host_model_i.trim(`DOCR_REG_POS_UP, `DOCR_SEL_CH2, k + 2);
            tp[0][order[k]] -= k + 1;
            tp[1][order[k]] += k + 2;
            settle();
            chk_dac(0);
            chk_dac(1);
        end
        // each range brings back its own positive trims
        for (int r = 0; r < 4; r++) begin
            set_range(r);
            settle();
            chk_dac(0);
            chk_dac(1);
        end
        // lower the positive trim of channel 2 on the last range as well
        docr_host_model_i.trim(`DOCR_REG_POS_DN, `DOCR_SEL_CH2, 2);
        tp[1][3] -= 2;
        settle();
        chk_dac(1);
        chk(docr_host_model_i.lost, 0, "missing ack");
        $display("test calibration done");
        // no-op keeps the enable; remote reset reloads the initial values and protects
        wr(`DOCR_REG_CMD, `DOCR_CMD_NOP);
        chk(wr_en, 1'b1, "no-op keeps enable");
        wr(`DOCR_REG_CMD, `DOCR_CMD_RESET);
        chk({wr_en, chan[1].value, chan[0].value}, 33'h0_0000_0000, "remote reset");
        val = '{0, 0};
        settle();
        chk_dac(0);
        chk_dac(1);
        // protected again, so this trim must not move channel 2
        wr(`DOCR_REG_NEG_UP, `DOCR_SEL_CH2);
        settle();
        chk_dac(1);
        // host setup reload also closes the trim window
        wr(`DOCR_REG_CMD, `DOCR_CMD_WREN);
        wr(`DOCR_REG_CMD, `DOCR_CMD_HOSTINIT);
        chk(wr_en, 1'b0, "host init protects");
        chk(link_cfg, {8'h01, 16'h2580, 2'h0, 8'h03, 8'h00, 8'h3c, 16'hffff},
            "link reload");
        $display("test commands done");
        end_of_test();
    end
endmodule : dual_output_calibration_regs_test
